// file: design/acm_pkg.sv
// constants, types and reset state of the converter control block
// assumes byte addressing on an 8-bit register address with 32-bit data
package acm_pkg;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL       = 8'h00;
	localparam logic [7:0] OFF_MODE       = 8'h04;
	localparam logic [7:0] OFF_SEQ_LO     = 8'h08;
	localparam logic [7:0] OFF_SEQ_HI     = 8'h0c;
	localparam logic [7:0] OFF_CH_SET     = 8'h10;
	localparam logic [7:0] OFF_CH_CLR     = 8'h14;
	localparam logic [7:0] OFF_CH_STATE   = 8'h18;
	localparam logic [7:0] OFF_LATEST     = 8'h20;
	localparam logic [7:0] OFF_IRQ_SET    = 8'h24;
	localparam logic [7:0] OFF_IRQ_CLR    = 8'h28;
	localparam logic [7:0] OFF_IRQ_MASK   = 8'h2c;
	localparam logic [7:0] OFF_IRQ_FLAGS  = 8'h30;
	localparam logic [7:0] OFF_IRQ_ACK    = 8'h34;
	localparam logic [7:0] OFF_OVERRUN    = 8'h3c;
	localparam logic [7:0] OFF_EXT_MODE   = 8'h40;
	localparam logic [7:0] OFF_CMP_WIN    = 8'h44;
	localparam logic [7:0] OFF_RESULT_0   = 8'h50;
	localparam logic [7:0] OFF_RESULT_15  = 8'h8c;
	localparam logic [7:0] OFF_PROT_MODE  = 8'he4;
	localparam logic [7:0] OFF_PROT_STATE = 8'he8;

	// command and mode fields
	localparam int CTRL_RESET_BIT    = 0;
	localparam int CTRL_START_BIT    = 1;
	localparam int MODE_TRIG_EN_BIT  = 0;
	localparam int MODE_TRIG_SEL_LSB = 1;
	localparam int MODE_LOW_RES_BIT  = 4;
	localparam int MODE_SLEEP_BIT    = 5;
	localparam int MODE_FAST_BIT     = 6;
	localparam int MODE_CONT_BIT     = 7;
	localparam int MODE_DIV_LSB      = 8;
	localparam int MODE_STARTUP_LSB  = 16;
	localparam int MODE_TRACK_LSB    = 24;
	localparam int MODE_ORDER_BIT    = 31;
	localparam logic [31:0] MODE_MASK = 32'h8f0fffff;

	// trigger source codes
	localparam logic [2:0] TRIG_EXT_CODE  = 3'h0;
	localparam logic [2:0] TRIG_LAST_CODE = 3'h3;

	// flag layout
	localparam int FLAG_READY_BIT = 24;
	localparam int FLAG_LOST_BIT  = 25;
	localparam logic [31:0] FLAG_MASK = 32'h0300ffff;
	localparam int LATEST_CH_LSB  = 12;

	// protection fields
	localparam int PROT_ON_BIT   = 0;
	localparam int PROT_KEY_LSB  = 8;
	localparam int PROT_VIOL_BIT = 0;
	localparam int PROT_SRC_LSB  = 8;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_WAKE  = 5'b00010,
		ST_SCAN  = 5'b00100,
		ST_TRACK = 5'b01000,
		ST_CONV  = 5'b10000
	} acm_fsm_type;

	typedef struct packed {
		logic [31:0]      mode;
		logic [31:0]      seq_lo;
		logic [31:0]      seq_hi;
		logic [15:0]      chen;
		logic [15:0]      latest;
		logic [15:0][9:0] result;
		logic [31:0]      imr;
		logic [31:0]      isr;
		logic [15:0]      over;
		logic [31:0]      emr;
		logic [31:0]      cwr;
		logic             wp_on;
		logic             wp_viol;
		logic [7:0]       wp_src;
		logic [31:0]      rdata;
		acm_fsm_type      fsm;
		logic [7:0]       div_cnt;
		logic             clk;
		logic [9:0]       wait_cnt;
		logic [3:0]       slot;
		logic [3:0]       chan;
		logic             core_on;
		logic             ref_on;
		logic             sample;
		logic             start;
		logic             irq;
		logic [3:0]       trig_s1;
		logic [3:0]       trig_s2;
		logic [3:0]       trig_prev;
		logic             done_s1;
		logic             done_s2;
		logic             done_prev;
		logic [9:0]       data_s1;
		logic [9:0]       data_s2;
	} acm_state_type;

	function automatic acm_state_type reset_state();
		acm_state_type s;
		s = '0;
		s.fsm = ST_IDLE;
		return s;
	endfunction : reset_state

	// start-up wait in converter clock periods
	function automatic logic [9:0] startup_periods(input logic [3:0] code);
		logic [9:0] p;
		p = 10'h000;
		unique case (code)
			4'h0: p = 10'h000;
			4'h1: p = 10'h008;
			4'h2: p = 10'h010;
			4'h3: p = 10'h018;
			4'h4: p = 10'h040;
			4'h5: p = 10'h050;
			4'h6: p = 10'h060;
			4'h7: p = 10'h070;
			4'h8: p = 10'h200;
			4'h9: p = 10'h240;
			4'ha: p = 10'h280;
			4'hb: p = 10'h2c0;
			4'hc: p = 10'h300;
			4'hd: p = 10'h340;
			4'he: p = 10'h380;
			4'hf: p = 10'h3c0;
		endcase
		return p;
	endfunction : startup_periods

endpackage : acm_pkg

// file: design/acm_top.sv
// converter control: registers, triggers, power modes, clock divider and sequencer
// assumes a converter cell that raises CELL_DONE after CELL_START with CELL_DATA stable
`timescale 1ns/1ns

module acm_top #(
	parameter logic [23:0] PROTECT_KEY = 24'h5a5a5a  // arbitrary unlock key value
) (
	// clock and reset
	input  wire logic        MCLK,
	input  wire logic        RESET_N,
	// register port
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	input  wire logic        REG_WRITE,
	input  wire logic        REG_READ,
	output logic      [31:0] REG_RDATA,
	// interrupt
	output logic             IRQ,
	// trigger sources
	input  wire logic        TRIG_EXT,
	input  wire logic        TRIG_TIMER0,
	input  wire logic        TRIG_TIMER1,
	input  wire logic        TRIG_TIMER2,
	// converter cell
	output logic             CELL_CLK,
	output logic             CELL_CORE_ON,
	output logic             CELL_REF_ON,
	output logic      [3:0]  CELL_CHANNEL,
	output logic             CELL_LOW_RES,
	output logic             CELL_SAMPLE,
	output logic             CELL_START,
	input  wire logic        CELL_DONE,
	input  wire logic [9:0]  CELL_DATA
);

	if (PROTECT_KEY == 24'h000000) begin : g_key_check
		$error("protection key must not be zero");
	end

	function automatic logic is_protected(input logic [7:0] a);
		return (a == acm_pkg::OFF_MODE) || (a == acm_pkg::OFF_SEQ_LO) ||
			(a == acm_pkg::OFF_SEQ_HI) || (a == acm_pkg::OFF_CH_SET) ||
			(a == acm_pkg::OFF_CH_CLR) || (a == acm_pkg::OFF_EXT_MODE) ||
			(a == acm_pkg::OFF_CMP_WIN);
	endfunction : is_protected

	function automatic logic [3:0] seq_channel(input logic [63:0] seq, input logic [3:0] slot);
		return seq[slot * 4 +: 4];
	endfunction : seq_channel

	acm_pkg::acm_state_type st_reg;
	acm_pkg::acm_state_type st_next;

	logic        soft_rst;
	logic        sw_start;
	logic        hw_fire;
	logic        start_req;
	logic        tick;
	logic        done_edge;
	logic        res_hit;
	logic [7:0]  res_off;
	logic [3:0]  res_idx;
	logic [7:0]  div;
	logic [2:0]  trig_sel;
	logic [3:0]  edges;
	logic [31:0] ack;
	logic [9:0]  sample_val;

	always_comb begin
		st_next = st_reg;
		st_next.rdata = '0;
		st_next.start = 1'b0;
		ack = '0;
		// pin synchronisers
		st_next.trig_s1 = {TRIG_TIMER2, TRIG_TIMER1, TRIG_TIMER0, TRIG_EXT};
		st_next.trig_s2 = st_reg.trig_s1;
		st_next.trig_prev = st_reg.trig_s2;
		st_next.done_s1 = CELL_DONE;
		st_next.done_s2 = st_reg.done_s1;
		st_next.done_prev = st_reg.done_s2;
		st_next.data_s1 = CELL_DATA;
		st_next.data_s2 = st_reg.data_s1;
		done_edge = st_reg.done_s2 && !st_reg.done_prev;

		// converter clock divider
		div = st_reg.mode[acm_pkg::MODE_DIV_LSB +: 8];
		tick = 1'b0;
		if (st_reg.div_cnt >= div) begin
			st_next.div_cnt = 8'h00;
			st_next.clk = ~st_reg.clk;
			tick = st_reg.clk;
		end else begin
			st_next.div_cnt = st_reg.div_cnt + 8'h01;
		end

		// trigger selection
		trig_sel = st_reg.mode[acm_pkg::MODE_TRIG_SEL_LSB +: 3];
		edges = st_reg.trig_s2 & ~st_reg.trig_prev;
		hw_fire = (trig_sel <= acm_pkg::TRIG_LAST_CODE) ? edges[trig_sel[1:0]] : 1'b0;
		soft_rst = REG_WRITE && (REG_ADDR == acm_pkg::OFF_CTRL) &&
			REG_WDATA[acm_pkg::CTRL_RESET_BIT];
		sw_start = REG_WRITE && (REG_ADDR == acm_pkg::OFF_CTRL) &&
			REG_WDATA[acm_pkg::CTRL_START_BIT];
		start_req = sw_start || (st_reg.mode[acm_pkg::MODE_TRIG_EN_BIT] && hw_fire) ||
			st_reg.mode[acm_pkg::MODE_CONT_BIT];

		// result register decode
		res_off = REG_ADDR - acm_pkg::OFF_RESULT_0;
		res_idx = res_off[5:2];
		res_hit = (REG_ADDR >= acm_pkg::OFF_RESULT_0) && (REG_ADDR <= acm_pkg::OFF_RESULT_15) &&
			(REG_ADDR[1:0] == 2'b00);

		// register writes
		if (REG_WRITE && is_protected(REG_ADDR) && st_reg.wp_on) begin
			st_next.wp_viol = 1'b1;
			st_next.wp_src = REG_ADDR;
		end else if (REG_WRITE) begin
			unique case (REG_ADDR)
				acm_pkg::OFF_MODE:     st_next.mode = REG_WDATA & acm_pkg::MODE_MASK;
				acm_pkg::OFF_SEQ_LO:   st_next.seq_lo = REG_WDATA;
				acm_pkg::OFF_SEQ_HI:   st_next.seq_hi = REG_WDATA;
				acm_pkg::OFF_CH_SET:   st_next.chen = st_reg.chen | REG_WDATA[15:0];
				acm_pkg::OFF_CH_CLR:   st_next.chen = st_reg.chen & ~REG_WDATA[15:0];
				acm_pkg::OFF_IRQ_SET:  st_next.imr = st_reg.imr | (REG_WDATA & acm_pkg::FLAG_MASK);
				acm_pkg::OFF_IRQ_CLR:  st_next.imr = st_reg.imr & ~REG_WDATA;
				acm_pkg::OFF_IRQ_ACK:  ack = REG_WDATA & acm_pkg::FLAG_MASK;
				acm_pkg::OFF_EXT_MODE: st_next.emr = REG_WDATA;
				acm_pkg::OFF_CMP_WIN:  st_next.cwr = REG_WDATA;
				acm_pkg::OFF_PROT_MODE: begin
					if (REG_WDATA[31:acm_pkg::PROT_KEY_LSB] == PROTECT_KEY) begin
						st_next.wp_on = REG_WDATA[acm_pkg::PROT_ON_BIT];
						st_next.wp_viol = 1'b0;
						st_next.wp_src = 8'h00;
					end
				end
				default: ;
			endcase
		end

		// register reads, unlisted offsets outside the result range read zero
		if (REG_READ) begin
			unique case (REG_ADDR)
				acm_pkg::OFF_MODE:      st_next.rdata = st_reg.mode;
				acm_pkg::OFF_SEQ_LO:    st_next.rdata = st_reg.seq_lo;
				acm_pkg::OFF_SEQ_HI:    st_next.rdata = st_reg.seq_hi;
				acm_pkg::OFF_CH_STATE:  st_next.rdata = {16'h0000, st_reg.chen};
				acm_pkg::OFF_LATEST:    st_next.rdata = {16'h0000, st_reg.latest};
				acm_pkg::OFF_IRQ_MASK:  st_next.rdata = st_reg.imr;
				acm_pkg::OFF_IRQ_FLAGS: st_next.rdata = st_reg.isr;
				acm_pkg::OFF_EXT_MODE:  st_next.rdata = st_reg.emr;
				acm_pkg::OFF_CMP_WIN:   st_next.rdata = st_reg.cwr;
				acm_pkg::OFF_OVERRUN: begin
					st_next.rdata = {16'h0000, st_reg.over};
					st_next.over = 16'h0000;
				end
				acm_pkg::OFF_PROT_MODE: st_next.rdata = {31'h00000000, st_reg.wp_on};
				acm_pkg::OFF_PROT_STATE: begin
					st_next.rdata = {16'h0000, st_reg.wp_src, 7'h00, st_reg.wp_viol};
				end
				default: begin
					if (res_hit) begin
						st_next.rdata = {22'h000000, st_reg.result[res_idx]};
					end
				end
			endcase
		end

		// sticky flags: acknowledge first so a same-cycle event wins
		st_next.isr = st_reg.isr & ~ack;
		sample_val = st_reg.data_s2;
		if (st_reg.mode[acm_pkg::MODE_LOW_RES_BIT]) begin
			sample_val = {2'b00, st_reg.data_s2[7:0]};
		end

		// sequencer
		unique case (st_reg.fsm)
			acm_pkg::ST_IDLE: begin
				if (start_req) begin
					st_next.slot = 4'h0;
					st_next.core_on = 1'b1;
					st_next.ref_on = 1'b1;
					if (st_reg.core_on) begin
						st_next.fsm = acm_pkg::ST_SCAN;
					end else begin
						st_next.wait_cnt = acm_pkg::startup_periods(
							st_reg.mode[acm_pkg::MODE_STARTUP_LSB +: 4]);
						st_next.fsm = acm_pkg::ST_WAKE;
					end
				end else begin
					st_next.core_on = !(st_reg.mode[acm_pkg::MODE_SLEEP_BIT] ||
						st_reg.mode[acm_pkg::MODE_FAST_BIT]);
					st_next.ref_on = !st_reg.mode[acm_pkg::MODE_SLEEP_BIT] ||
						st_reg.mode[acm_pkg::MODE_FAST_BIT];
				end
			end
			acm_pkg::ST_WAKE: begin
				if (st_reg.wait_cnt == 10'h000) begin
					st_next.fsm = acm_pkg::ST_SCAN;
				end else if (tick) begin
					st_next.wait_cnt = st_reg.wait_cnt - 10'h001;
				end
			end
			acm_pkg::ST_SCAN: begin
				if (st_reg.chen[st_reg.slot]) begin
					st_next.chan = st_reg.mode[acm_pkg::MODE_ORDER_BIT] ?
						seq_channel({st_reg.seq_hi, st_reg.seq_lo}, st_reg.slot) :
						st_reg.slot;
					st_next.wait_cnt = {6'h00, st_reg.mode[acm_pkg::MODE_TRACK_LSB +: 4]};
					st_next.sample = 1'b1;
					st_next.fsm = acm_pkg::ST_TRACK;
				end else if (st_reg.slot == 4'hf) begin
					st_next.fsm = acm_pkg::ST_IDLE;
				end else begin
					st_next.slot = st_reg.slot + 4'h1;
				end
			end
			acm_pkg::ST_TRACK: begin
				if (tick) begin
					if (st_reg.wait_cnt == 10'h000) begin
						st_next.sample = 1'b0;
						st_next.start = 1'b1;
						st_next.fsm = acm_pkg::ST_CONV;
					end else begin
						st_next.wait_cnt = st_reg.wait_cnt - 10'h001;
					end
				end
			end
			acm_pkg::ST_CONV: begin
				if (done_edge) begin
					st_next.result[st_reg.chan] = sample_val;
					st_next.latest = {st_reg.chan, 2'b00, sample_val};
					st_next.isr[st_reg.chan] = 1'b1;
					st_next.isr[acm_pkg::FLAG_READY_BIT] = 1'b1;
					if (st_reg.isr[st_reg.chan]) begin
						st_next.over[st_reg.chan] = 1'b1;
					end
					if (st_reg.isr[acm_pkg::FLAG_READY_BIT]) begin
						st_next.isr[acm_pkg::FLAG_LOST_BIT] = 1'b1;
					end
					if (st_reg.slot == 4'hf) begin
						st_next.fsm = acm_pkg::ST_IDLE;
					end else begin
						st_next.slot = st_reg.slot + 4'h1;
						st_next.fsm = acm_pkg::ST_SCAN;
					end
				end
			end
			default: st_next.fsm = acm_pkg::ST_IDLE;
		endcase

		st_next.irq = |(st_next.isr & st_next.imr);
		if (soft_rst) begin
			st_next = acm_pkg::reset_state();
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			st_reg <= acm_pkg::reset_state();
		end else begin
			st_reg <= st_next;
		end
	end

	assign REG_RDATA    = st_reg.rdata;
	assign IRQ          = st_reg.irq;
	assign CELL_CLK     = st_reg.clk;
	assign CELL_CORE_ON = st_reg.core_on;
	assign CELL_REF_ON  = st_reg.ref_on;
	assign CELL_CHANNEL = st_reg.chan;
	assign CELL_LOW_RES = st_reg.mode[acm_pkg::MODE_LOW_RES_BIT];
	assign CELL_SAMPLE  = st_reg.sample;
	assign CELL_START   = st_reg.start;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESET_N);

	property p_soft_reset;
		soft_rst |=> (st_reg.mode == 32'h0 && st_reg.chen == 16'h0 && st_reg.fsm == acm_pkg::ST_IDLE);
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset left state");

	property p_sw_start;
		(sw_start && !soft_rst && st_reg.fsm == acm_pkg::ST_IDLE) |=> st_reg.fsm != acm_pkg::ST_IDLE;
	endproperty
	a_sw_start: assert property (p_sw_start) else $error("start command not taken");

	property p_hw_off;
		(st_reg.fsm == acm_pkg::ST_IDLE && !st_reg.mode[acm_pkg::MODE_TRIG_EN_BIT] && !sw_start &&
			!st_reg.mode[acm_pkg::MODE_CONT_BIT]) |=> st_reg.fsm == acm_pkg::ST_IDLE;
	endproperty
	a_hw_off: assert property (p_hw_off) else $error("start without trigger");

	property p_reserved_src;
		(trig_sel > acm_pkg::TRIG_LAST_CODE) |-> !hw_fire;
	endproperty
	a_reserved_src: assert property (p_reserved_src) else $error("reserved source fired");

	property p_low_res;
		(st_reg.fsm == acm_pkg::ST_CONV && done_edge && CELL_LOW_RES && !soft_rst)
			|=> st_reg.latest[9:8] == 2'b00;
	endproperty
	a_low_res: assert property (p_low_res) else $error("low resolution result too wide");

	property p_sleep_core;
		(st_reg.fsm == acm_pkg::ST_IDLE && !start_req && !soft_rst) |=> CELL_CORE_ON ==
			!($past(st_reg.mode[acm_pkg::MODE_SLEEP_BIT]) || $past(st_reg.mode[acm_pkg::MODE_FAST_BIT]));
	endproperty
	a_sleep_core: assert property (p_sleep_core) else $error("core power wrong in idle");

	property p_fast_ref;
		(st_reg.fsm == acm_pkg::ST_IDLE && !start_req && !soft_rst) |=> CELL_REF_ON ==
			(!$past(st_reg.mode[acm_pkg::MODE_SLEEP_BIT]) || $past(st_reg.mode[acm_pkg::MODE_FAST_BIT]));
	endproperty
	a_fast_ref: assert property (p_fast_ref) else $error("reference power wrong in idle");

	property p_free_run;
		(st_reg.fsm == acm_pkg::ST_IDLE && st_reg.mode[acm_pkg::MODE_CONT_BIT] && !soft_rst)
			|=> st_reg.fsm != acm_pkg::ST_IDLE;
	endproperty
	a_free_run: assert property (p_free_run) else $error("continuous mode waited");

	property p_div_wrap;
		(st_reg.div_cnt == div && !soft_rst) |=> CELL_CLK != $past(CELL_CLK) && st_reg.div_cnt == 8'h00;
	endproperty
	a_div_wrap: assert property (p_div_wrap) else $error("converter clock did not toggle");

	property p_protect;
		(REG_WRITE && REG_ADDR == acm_pkg::OFF_MODE && st_reg.wp_on) |=> $stable(st_reg.mode) && st_reg.wp_viol;
	endproperty
	a_protect: assert property (p_protect) else $error("protected mode write took effect");

	property p_result_read;
		(REG_READ && res_hit) |=> REG_RDATA == {22'h000000, $past(st_reg.result[res_idx])};
	endproperty
	a_result_read: assert property (p_result_read) else $error("result read mismatch");

	property p_prot_state;
		(REG_READ && REG_ADDR == acm_pkg::OFF_PROT_STATE) |=> REG_RDATA[0] == $past(st_reg.wp_viol);
	endproperty
	a_prot_state: assert property (p_prot_state) else $error("protection status mismatch");

	property p_busy_ignore;
		(st_reg.fsm == acm_pkg::ST_CONV && !done_edge && !soft_rst) |=> st_reg.fsm == acm_pkg::ST_CONV;
	endproperty
	a_busy_ignore: assert property (p_busy_ignore) else $error("sequence disturbed");

	c_seq_end: cover property (st_reg.fsm == acm_pkg::ST_CONV ##1 st_reg.fsm == acm_pkg::ST_IDLE);
	c_hw_start: cover property (hw_fire && st_reg.mode[acm_pkg::MODE_TRIG_EN_BIT] &&
		st_reg.fsm == acm_pkg::ST_IDLE);
	c_violation: cover property (!st_reg.wp_viol ##1 st_reg.wp_viol);
	c_wake: cover property (st_reg.fsm == acm_pkg::ST_WAKE ##1 st_reg.fsm == acm_pkg::ST_SCAN);

endmodule : acm_top

// file: verif/acm_cell_model.sv
// behavioural converter cell on the far side of the controller
// assumes start is a one-cycle pulse registered on the rising clock edge
`timescale 1ns/1ns

module acm_cell_model (
	// clock
	input  wire logic       clk,
	// controller side
	input  wire logic       start,
	input  wire logic [3:0] channel,
	output logic            done,
	output logic [9:0]      data
);
	initial begin
		done = 1'b0;
		data = 10'h2aa;
		forever begin
			@(posedge clk);
			if (start === 1'b1) begin
				data <= {~channel, 6'h35};
				repeat (5) @(posedge clk);
				done <= 1'b1;
				repeat (6) @(posedge clk);
				done <= 1'b0;
				// released data no longer shows the result
				data <= ~data;
			end
		end
	end
endmodule : acm_cell_model

// file: verif/adc_control_mode_interface_test.sv
// self-checking bench of the converter control block
// assumes the behavioural cell model answers every conversion start
`timescale 1ns/1ns

module adc_control_mode_interface_test;
	localparam logic [23:0] KEY = 24'h3c3c3c;  // arbitrary unlock key value
	logic        mclk      = 1'b0;
	logic        reset_n   = 1'b0;
	logic [7:0]  reg_addr  = 8'h00;
	logic [31:0] reg_wdata = 32'h00000000;
	logic        reg_write = 1'b0;
	logic        reg_read  = 1'b0;
	logic [3:0]  trig      = 4'h0;
	logic [31:0] reg_rdata;
	logic        irq;
	logic        cell_clk;
	logic        core_on;
	logic        ref_on;
	logic        low_res;
	logic        sample;
	logic        start;
	logic        done;
	logic [3:0]  chan;
	logic [9:0]  data;
	int          err_total       = 0;
	int          samples_checked = 0;
	int          cycle_count     = 0;

	always #20 mclk = ~mclk;

	acm_top #(.PROTECT_KEY(KEY)) acm_top_i (
		.MCLK(mclk), .RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WRITE(reg_write), .REG_READ(reg_read), .REG_RDATA(reg_rdata), .IRQ(irq),
		.TRIG_EXT(trig[0]), .TRIG_TIMER0(trig[1]), .TRIG_TIMER1(trig[2]),
		.TRIG_TIMER2(trig[3]), .CELL_CLK(cell_clk), .CELL_CORE_ON(core_on),
		.CELL_REF_ON(ref_on), .CELL_CHANNEL(chan), .CELL_LOW_RES(low_res),
		.CELL_SAMPLE(sample), .CELL_START(start), .CELL_DONE(done), .CELL_DATA(data)
	);

	acm_cell_model acm_cell_model_i (
		.clk(mclk), .start(start), .channel(chan), .done(done), .data(data)
	);

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run

	always @(posedge mclk) begin
		cycle_count++;
		if (cycle_count > 30000) begin
			err_total++;
			complete_run();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic cycles(input int n);
		repeat (n) @(posedge mclk);
	endtask : cycles

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_write <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_write <= 1'b0;
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_read <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : rd_chk

	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 400) begin
			@(posedge mclk);
			n++;
		end
		chk(irq, 1'b1);
	endtask : wait_irq

	// value the cell model returns for a channel
	function automatic logic [9:0] cell_val(input logic [3:0] c);
		return {~c, 6'h35};
	endfunction : cell_val

	task automatic t_reset_values();
		logic [7:0] offs [13] = '{8'h04, 8'h08, 8'h0c, 8'h18, 8'h20, 8'h2c, 8'h30,
			8'h3c, 8'h40, 8'h44, 8'h50, 8'h8c, 8'he4};
		foreach (offs[i]) rd_chk(offs[i], 32'h00000000);
		rd_chk(8'he8, 32'h00000000);
		rd_chk(8'h1c, 32'h00000000);
		chk({core_on, ref_on}, 2'b11);
		$display("test reset_values done");
	endtask : t_reset_values

	task automatic t_protect();
		wr(8'h04, 32'hffffffff);
		rd_chk(8'h04, 32'h8f0fffff);
		wr(8'he4, {KEY, 8'h01});
		rd_chk(8'he4, 32'h00000001);
		wr(8'h04, 32'h00000000);
		rd_chk(8'h04, 32'h8f0fffff);
		rd_chk(8'he8, 32'h00000401);
		wr(8'he4, {KEY, 8'h00});
		rd_chk(8'he8, 32'h00000000);
		wr(8'h00, 32'h00000000);
		rd_chk(8'h04, 32'h8f0fffff);
		wr(8'h00, 32'h00000001);
		rd_chk(8'h04, 32'h00000000);
		$display("test protect done");
	endtask : t_protect

	task automatic t_sw_start();
		wr(8'h10, 32'h00000009);
		wr(8'h24, 32'h01000000);
		wr(8'h00, 32'h00000000);
		cycles(60);
		chk(irq, 1'b0);
		wr(8'h00, 32'h00000002);
		wait_irq();
		cycles(60);
		rd_chk(8'h50, {22'h0, cell_val(4'h0)});
		rd_chk(8'h5c, {22'h0, cell_val(4'h3)});
		rd_chk(8'h20, {16'h0, 4'h3, 2'b00, cell_val(4'h3)});
		rd_chk(8'h30, 32'h03000009);
		rd_chk(8'h2c, 32'h01000000);
		wr(8'h28, 32'h01000000);
		cycles(2);
		chk(irq, 1'b0);
		wr(8'h24, 32'h01000000);
		cycles(2);
		chk(irq, 1'b1);
		wr(8'h34, 32'hffffffff);
		cycles(2);
		chk(irq, 1'b0);
		$display("test sw_start done");
	endtask : t_sw_start

	task automatic t_low_res();
		int n;
		n = 0;
		wr(8'h04, 32'h03000110);
		wr(8'h00, 32'h00000002);
		// look just after each edge so the launching edge is settled
		while (sample !== 1'b1 && n < 100) begin
			cycles(1);
			#1;
			n++;
		end
		n = 0;
		while (sample === 1'b1 && n < 100) begin
			cycles(1);
			#1;
			n++;
		end
		chk(n > 12 && n <= 16, 1'b1);
		chk(low_res, 1'b1);
		wait_irq();
		cycles(100);
		rd_chk(8'h50, {22'h0, cell_val(4'h0) & 10'h0ff});
		wr(8'h34, 32'hffffffff);
		$display("test low_res done");
	endtask : t_low_res

	task automatic t_custom_order();
		wr(8'h08, 32'h00000005);
		wr(8'h04, 32'h80000000);
		wr(8'h00, 32'h00000002);
		wait_irq();
		cycles(60);
		rd_chk(8'h64, {22'h0, cell_val(4'h5)});
		wr(8'h34, 32'hffffffff);
		$display("test custom_order done");
	endtask : t_custom_order

	task automatic pulse(input logic [3:0] p);
		trig <= p;
		cycles(5);
		trig <= 4'h0;
		cycles(90);
	endtask : pulse

	task automatic t_triggers();
		logic [3:0] sel;
		for (int c = 0; c < 8; c++) begin
			sel = (c < 4) ? 4'h1 << c : 4'h0;
			wr(8'h34, 32'hffffffff);
			wr(8'h04, {28'h0, c[2:0], 1'b0});
			pulse(4'hf);
			chk(irq, 1'b0);
			wr(8'h04, {28'h0, c[2:0], 1'b1});
			pulse(~sel);
			chk(irq, 1'b0);
			pulse(sel);
			chk(irq, c < 4);
		end
		wr(8'h04, 32'h00000000);
		wr(8'h34, 32'hffffffff);
		$display("test triggers done");
	endtask : t_triggers

	task automatic t_power();
		int n;
		for (int m = 0; m < 4; m++) begin
			wr(8'h04, m << 5);
			cycles(4);
			chk({core_on, ref_on}, {m == 0, m != 1});
		end
		wr(8'h04, 32'h00010020);
		wr(8'h00, 32'h00000002);
		cycles(3);
		chk(core_on, 1'b1);
		// start-up code 1 is 8 converter periods of 2 cycles, plus wake and scan steps
		n = 3;
		while (sample !== 1'b1 && n < 100) begin
			cycles(1);
			#1;
			n++;
		end
		chk(n >= 16 && n <= 19, 1'b1);
		wait_irq();
		cycles(60);
		chk({core_on, ref_on}, 2'b00);
		wr(8'h34, 32'hffffffff);
		$display("test power done");
	endtask : t_power

	task automatic t_divider();
		int  n;
		int  rises;
		logic prev;
		for (int d = 0; d < 6; d += 5) begin
			wr(8'h04, d << 8);
			cycles(20);
			n     = 0;
			rises = 0;
			prev  = cell_clk;
			while (rises < 2 && n < 200) begin
				@(posedge mclk);
				#1;
				if (rises == 1)
					n++;
				if (!prev && cell_clk)
					rises++;
				prev = cell_clk;
			end
			chk(n, 2 * (d + 1));
		end
		$display("test divider done");
	endtask : t_divider

	task automatic t_continuous();
		wr(8'h04, 32'h00000080);
		wait_irq();
		wr(8'h34, 32'hffffffff);
		cycles(2);
		wait_irq();
		wr(8'h04, 32'h00000000);
		cycles(90);
		wr(8'h34, 32'hffffffff);
		cycles(90);
		chk(irq, 1'b0);
		$display("test continuous done");
	endtask : t_continuous

	initial begin
		cycles(20);
		reset_n <= 1'b1;
		cycles(2);
		t_reset_values();
		t_protect();
		t_sw_start();
		t_low_res();
		t_custom_order();
		t_triggers();
		t_power();
		t_divider();
		t_continuous();
		complete_run();
	end
endmodule : adc_control_mode_interface_test
